// File: design/sbe_map.svh
`ifndef SBE_MAP_SVH
`define SBE_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// Operating state byte layout
`define SBE_OP_FILL_LSB      1
`define SBE_OP_FILL_MSB      3
`define SBE_OP_CRIT_BIT      5
`define SBE_OP_HEAT_BIT      6
`define SBE_OP_RESET         8'h00

////////////////////////////////////////////////////////////////////////////////
// Fault state byte layout
`define SBE_ERR_GEN_BIT      0
`define SBE_ERR_STATIC_BIT   1
`define SBE_ERR_RESET        8'h00

////////////////////////////////////////////////////////////////////////////////
// Compact telegram state byte layout
`define SBE_T9_INVALID_BIT   0
`define SBE_T9_TDIFF_LSB     1
`define SBE_T9_TDIFF_MSB     2
`define SBE_T9_FILL_LSB      3
`define SBE_T9_FILL_MSB      4
`define SBE_T9_ZERO_BIT      5
`define SBE_T9_ONE_BIT       6
`define SBE_T9_HEAT_BIT      7
`define SBE_T9_RESET         8'h40

////////////////////////////////////////////////////////////////////////////////
// Timing, in seconds of the seconds tick
`define SBE_SHORT_AVG_S      10
`define SBE_STALE_S          6'h0a
`define SBE_STATIC_S         7'h3c
`define SBE_STATIC_SAT       7'h3d

////////////////////////////////////////////////////////////////////////////////
// Temperature difference class limits, tenths of a kelvin
`define SBE_TDIFF_LIM0       8'h1f
`define SBE_TDIFF_LIM1       8'h3f
`define SBE_TDIFF_LIM2       8'h4f

////////////////////////////////////////////////////////////////////////////////
// Buffer fill class limits, percent and eighths
`define SBE_FILL_PCT_HI      80
`define SBE_FILL_PCT_MID     66
`define SBE_FILL_PCT_LO      33
`define SBE_FILL_PCT_FULL    100
`define SBE_FILL_EIGHTHS     8

`endif

// File: design/sbe_pkg.sv
package sbe_pkg;

	typedef enum logic {
		SBE_SHORT_AVG,
		SBE_LONG_AVG
	} sbe_avg_mode_t;

	typedef struct packed {
		logic criterion;
		logic on;
	} sbe_heat_t;

	typedef struct packed {
		logic [7:0] opState;
		logic [7:0] faultState;
		logic [7:0] telegramState;
	} sbe_status_t;

endpackage

// File: design/sbe_fill_classifier.sv
`timescale 1ns/1ps
`include "sbe_map.svh"

module sbe_fill_classifier
	import sbe_pkg::*;
#(
	parameter int FILL_W    = 8,
	parameter int BUF_DEPTH = 200
) (
	// Buffer occupancy
	input  wire logic [FILL_W-1:0] fillCount,
	// Classes
	output logic      [2:0]        eighthCode,
	output logic      [1:0]        pctCode
);

	if (FILL_W < 1 || FILL_W > 16 || BUF_DEPTH < 1 || BUF_DEPTH >= (1 << FILL_W)) begin
		$error("BUF_DEPTH does not fit FILL_W");
	end

	// Scaled comparison of fill against a fraction of the depth
	function automatic logic above(input int fill, input int num, input int den);
		above = fill * den > num * BUF_DEPTH;
	endfunction

	int fill;

	always_comb begin
		fill       = int'(fillCount);
		eighthCode = 3'h0;
		// Highest n with fill above n/8 of the depth
		for (int n = 1; n < `SBE_FILL_EIGHTHS; n++) begin
			if (above(fill, n, `SBE_FILL_EIGHTHS))
				eighthCode = 3'(n); // RULE_02
		end
		if (above(fill, `SBE_FILL_PCT_HI, `SBE_FILL_PCT_FULL))
			pctCode = 2'h0; // RULE_10
		else if (above(fill, `SBE_FILL_PCT_MID, `SBE_FILL_PCT_FULL))
			pctCode = 2'h1; // RULE_10
		else if (above(fill, `SBE_FILL_PCT_LO, `SBE_FILL_PCT_FULL))
			pctCode = 2'h2; // RULE_10
		else
			pctCode = 2'h3; // RULE_10
	end

endmodule

// File: design/sbe_status_encoder.sv
`timescale 1ns/1ps
`include "sbe_map.svh"

// How it works
// RULE_01 - Separate operating and fault state bytes
// RULE_02 - Operating bits 3:1 give fill eighths
// RULE_03 - Operating bit 5 mirrors heating criterion
// RULE_04 - Heater on in operating bit 6, telegram bit 7
// RULE_05 - Short averaging: fault after 10 s without sample
// RULE_06 - Long averaging: fault below half expected samples
// RULE_07 - Fault bit 1 after fault beyond one minute; counts stale or virtual temperature check fail, not long-averaging low fill
// RULE_08 - Telegram bit 0 set when data invalid
// RULE_09 - Telegram bits 2:1 classify temperature difference
// RULE_10 - Telegram bits 4:3 classify buffer fill percent
// RULE_11 - Telegram state is its own byte
// RULE_12 - Reserved bits held constant
module sbe_status_encoder
	import sbe_pkg::*;
#(
	parameter int FILL_W    = 8,
	parameter int AVG_W     = 8,
	parameter int BUF_DEPTH = 200
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Measurement and averaging
	input  wire logic              secTick,
	input  wire logic              newSample,
	input  wire logic [FILL_W-1:0] fillCount,
	input  wire logic [AVG_W-1:0]  avgTimeSec,
	input  wire logic              dataValid,
	input  wire logic              virtualTemperatureCheckFail,
	input  wire logic [7:0]        tempDiff,
	// Heating
	input  wire sbe_heat_t         heat,
	// Status bytes
	output sbe_status_t            status
);

	if (AVG_W < 4 || AVG_W > 16) begin
		$error("AVG_W out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rstMeta;
	logic rstSync;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fill classes
	logic [2:0] eighthCode;
	logic [1:0] pctCode;

	sbe_fill_classifier #(
		.FILL_W    (FILL_W),
		.BUF_DEPTH (BUF_DEPTH)
	) u_fill (
		.fillCount  (fillCount),
		.eighthCode (eighthCode),
		.pctCode    (pctCode)
	);

	function automatic logic [1:0] tdiffClass(input logic [7:0] d);
		if (d <= `SBE_TDIFF_LIM0)
			tdiffClass = 2'h0;
		else if (d <= `SBE_TDIFF_LIM1)
			tdiffClass = 2'h1;
		else if (d <= `SBE_TDIFF_LIM2)
			tdiffClass = 2'h2;
		else
			tdiffClass = 2'h3;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Seconds since last sample
	logic [5:0] staleSec;
	logic       stale;

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync)
			staleSec <= 6'h00;
		else if (newSample)
			staleSec <= 6'h00;
		else if (secTick && staleSec != `SBE_STALE_S)
			staleSec <= staleSec + 6'h01;
	end

	assign stale = (staleSec == `SBE_STALE_S);

	////////////////////////////////////////////////////////////////////////////////
	// General fault
	sbe_avg_mode_t mode;
	logic          lowFill;
	logic          genFault;

	assign mode    = (int'(avgTimeSec) < `SBE_SHORT_AVG_S) ? SBE_SHORT_AVG : SBE_LONG_AVG;
	assign lowFill = (int'(fillCount) * 2 < int'(avgTimeSec));

	always_comb begin
		unique case (mode)
			SBE_SHORT_AVG: genFault = stale; // RULE_05
			SBE_LONG_AVG:  genFault = lowFill; // RULE_06
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Persistent fault
	logic [6:0] staticSec;
	logic       staticCause;

	assign staticCause = virtualTemperatureCheckFail | stale;

	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync)
			staticSec <= 7'h00;
		else if (!staticCause)
			staticSec <= 7'h00;
		else if (secTick && staticSec != `SBE_STATIC_SAT)
			staticSec <= staticSec + 7'h01; // RULE_07
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status bytes
	logic [7:0] next_opState;
	logic [7:0] next_faultState;
	logic [7:0] next_telegramState;
	logic [7:0] operatingStateByte;
	logic [7:0] faultStateByte;
	logic [7:0] compactTelegramStateByte;

	always_comb begin
		next_opState                                    = `SBE_OP_RESET; // RULE_12
		next_opState[`SBE_OP_FILL_MSB:`SBE_OP_FILL_LSB] = eighthCode; // RULE_02
		next_opState[`SBE_OP_CRIT_BIT]                  = heat.criterion; // RULE_03
		next_opState[`SBE_OP_HEAT_BIT]                  = heat.on; // RULE_04
	end

	always_comb begin
		next_faultState                      = `SBE_ERR_RESET; // RULE_12
		next_faultState[`SBE_ERR_GEN_BIT]    = genFault;
		next_faultState[`SBE_ERR_STATIC_BIT] = (staticSec > `SBE_STATIC_S); // RULE_07
	end

	always_comb begin
		next_telegramState                                      = `SBE_T9_RESET; // RULE_12
		next_telegramState[`SBE_T9_INVALID_BIT]                 = ~dataValid; // RULE_08
		next_telegramState[`SBE_T9_TDIFF_MSB:`SBE_T9_TDIFF_LSB] = tdiffClass(tempDiff); // RULE_09
		next_telegramState[`SBE_T9_FILL_MSB:`SBE_T9_FILL_LSB]   = pctCode; // RULE_10
		next_telegramState[`SBE_T9_HEAT_BIT]                    = heat.on; // RULE_04
	end

	// Operating and fault bytes kept apart
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync) begin
			operatingStateByte <= `SBE_OP_RESET;
			faultStateByte     <= `SBE_ERR_RESET;
		end else begin
			operatingStateByte <= next_opState; // RULE_01
			faultStateByte     <= next_faultState; // RULE_01
		end
	end

	// Compact telegram byte built from its own terms
	always_ff @(posedge clk or negedge rstSync) begin
		if (!rstSync)
			compactTelegramStateByte <= `SBE_T9_RESET;
		else
			compactTelegramStateByte <= next_telegramState; // RULE_11
	end

	assign status = {operatingStateByte, faultStateByte, compactTelegramStateByte};

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync);

	sequence s_stale_short;
		stale && mode == SBE_SHORT_AVG;
	endsequence

	sequence s_long_low;
		mode == SBE_LONG_AVG && lowFill;
	endsequence

	sequence s_static_long;
		staticCause && secTick && staticSec == `SBE_STATIC_S;
	endsequence

	a_reserved_const: assert property ( // RULE_12
		status.opState[0] == 1'b0 && status.opState[4] == 1'b0 && status.opState[7] == 1'b0
		&& status.faultState[7:2] == 6'h00
		&& status.telegramState[5] == 1'b0 && status.telegramState[6] == 1'b1)
		else $error("reserved status bit wrong");

	a_fill_eighths: assert property ( // RULE_02
		##1 (int'(status.opState[3:1]) + 1) * BUF_DEPTH >= int'($past(fillCount)) * 8
		&& (status.opState[3:1] == 3'h0
		|| int'(status.opState[3:1]) * BUF_DEPTH < int'($past(fillCount)) * 8))
		else $error("fill eighths code wrong");

	a_crit_follow: assert property ( // RULE_03
		heat.criterion |=> status.opState[5] == 1'b1)
		else $error("heating criterion not shown");

	a_heat_both: assert property ( // RULE_04
		##1 status.opState[6] == $past(heat.on) && status.telegramState[7] == status.opState[6])
		else $error("heater state mismatch");

	a_stale_fault: assert property ( // RULE_05
		s_stale_short |=> status.faultState[0])
		else $error("short averaging fault missing");

	a_low_fill: assert property ( // RULE_06
		s_long_low |=> status.faultState[0])
		else $error("long averaging fault missing");

	a_stale_timing: assert property ( // RULE_05
		newSample ##1 (!newSample && mode == SBE_SHORT_AVG)[*2] |=> !status.faultState[0])
		else $error("stale fault too early");

	a_static_fault: assert property ( // RULE_07
		s_static_long ##1 staticCause |=> status.faultState[1])
		else $error("persistent fault missing");

	a_static_clear: assert property ( // RULE_07
		!staticCause |=> ##1 !status.faultState[1])
		else $error("persistent fault without cause");

	a_data_invalid: assert property ( // RULE_08
		##1 status.telegramState[0] == !$past(dataValid))
		else $error("data invalid bit wrong");

	a_tdiff_class: assert property ( // RULE_09
		tempDiff > `SBE_TDIFF_LIM2 |=> status.telegramState[2:1] == 2'h3)
		else $error("temperature class wrong");

	a_fill_pct: assert property ( // RULE_10
		int'(fillCount) * 100 > 80 * BUF_DEPTH |=> status.telegramState[4:3] == 2'h0)
		else $error("fill percent class wrong");

	a_fill_upper: assert property ( // RULE_10
		int'(fillCount) * `SBE_FILL_PCT_FULL > `SBE_FILL_PCT_MID * BUF_DEPTH
		&& int'(fillCount) * `SBE_FILL_PCT_FULL <= `SBE_FILL_PCT_HI * BUF_DEPTH
		|=> status.telegramState[4:3] == 2'h1)
		else $error("upper fill class wrong");

	a_fill_half: assert property ( // RULE_10
		int'(fillCount) * `SBE_FILL_PCT_FULL > `SBE_FILL_PCT_LO * BUF_DEPTH
		&& int'(fillCount) * `SBE_FILL_PCT_FULL <= `SBE_FILL_PCT_MID * BUF_DEPTH
		|=> status.telegramState[4:3] == 2'h2)
		else $error("middle fill class wrong");

	a_fill_low: assert property ( // RULE_10
		int'(fillCount) * `SBE_FILL_PCT_FULL <= `SBE_FILL_PCT_LO * BUF_DEPTH
		|=> status.telegramState[4:3] == 2'h3)
		else $error("low fill class wrong");

	a_crit_clear: assert property ( // RULE_03
		!heat.criterion |=> status.opState[5] == 1'b0)
		else $error("heating criterion shown while unmet");

	a_tdiff_low: assert property ( // RULE_09
		tempDiff <= `SBE_TDIFF_LIM0 |=> status.telegramState[2:1] == 2'h0)
		else $error("low temperature class wrong");

	a_tdiff_mid: assert property ( // RULE_09
		tempDiff > `SBE_TDIFF_LIM0 && tempDiff <= `SBE_TDIFF_LIM1
		|=> status.telegramState[2:1] == 2'h1)
		else $error("middle temperature class wrong");

	a_tdiff_high: assert property ( // RULE_09
		tempDiff > `SBE_TDIFF_LIM1 && tempDiff <= `SBE_TDIFF_LIM2
		|=> status.telegramState[2:1] == 2'h2)
		else $error("high temperature class wrong");

	a_long_clear: assert property ( // RULE_06
		int'(avgTimeSec) >= `SBE_SHORT_AVG_S && int'(fillCount) * 2 >= int'(avgTimeSec)
		|=> !status.faultState[0])
		else $error("long averaging fault without cause");

	sequence s_fresh_short;
		newSample ##1 int'(avgTimeSec) < `SBE_SHORT_AVG_S;
	endsequence

	a_sample_clear: assert property ( // RULE_05
		s_fresh_short |=> !status.faultState[0])
		else $error("short averaging fault after sample");

	a_static_early: assert property ( // RULE_07
		staticSec <= `SBE_STATIC_S |=> !status.faultState[1])
		else $error("persistent fault too early");

	a_stale_bound: assert property ( // RULE_05
		staleSec <= `SBE_STALE_S)
		else $error("stale counter overran");

endmodule

// File: dv/sbe_host_logger.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Host side: splits the polled status into its three bytes
module sbe_host_logger
	import sbe_pkg::*;
(
	// Status as polled
	input  wire sbe_status_t status,
	// Decoded bytes
	output logic [7:0]       opByte,
	output logic [7:0]       faultByte,
	output logic [7:0]       telByte
);
	assign opByte    = status.opState;
	assign faultByte = status.faultState;
	assign telByte   = status.telegramState;
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps

module tb;
	import sbe_pkg::*;
	logic        clk;
	logic        rst_n;
	logic        secTick;
	logic        newSample;
	logic        dataValid;
	logic        virtualTemperatureCheckFail;
	logic [7:0]  fillCount;
	logic [7:0]  avgTimeSec;
	logic [7:0]  tempDiff;
	logic [7:0]  opByte;
	logic [7:0]  faultByte;
	logic [7:0]  telByte;
	logic [31:0] seed;
	sbe_heat_t   heat;
	sbe_status_t status;
	int          err_count;
	int          n_compared;
	logic [7:0]  cf [10] = '{0, 25, 26, 66, 67, 132, 133, 160, 161, 200};
	logic [7:0]  ct [10] = '{31, 32, 63, 64, 79, 80, 0, 255, 1, 100};
	logic [7:0]  la [5]  = '{9, 10, 10, 20, 20};
	logic [7:0]  lf [5]  = '{0, 4, 5, 9, 10};
	logic [7:0]  le [5]  = '{0, 1, 0, 1, 0};

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	sbe_status_encoder sbe_status_encoder_i (.clk(clk), .rst_n(rst_n), .secTick(secTick),
		.newSample(newSample), .fillCount(fillCount), .avgTimeSec(avgTimeSec),
		.dataValid(dataValid),
		.virtualTemperatureCheckFail(virtualTemperatureCheckFail), .tempDiff(tempDiff),
		.heat(heat), .status(status));
	sbe_host_logger sbe_host_logger_i (.status(status), .opByte(opByte),
		.faultByte(faultByte), .telByte(telByte));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	function logic [7:0] exp_op(input int f, input sbe_heat_t h);
		int n;
		n = 0;
		for (int i = 1; i < 8; i++) if (f * 8 > i * 200) n = i;
		return {1'b0, h.on, h.criterion, 1'b0, n[2:0], 1'b0};
	endfunction

	function logic [7:0] exp_tel(input int f, input int t, input sbe_heat_t h, input logic v);
		logic [1:0] pc;
		logic [1:0] tc;
		pc = (f * 100 > 16000) ? 2'h0 : (f * 100 > 13200) ? 2'h1 : (f * 100 > 6600) ? 2'h2 : 2'h3;
		tc = (t <= 31) ? 2'h0 : (t <= 63) ? 2'h1 : (t <= 79) ? 2'h2 : 2'h3;
		return {h.on, 1'b1, 1'b0, pc, tc, ~v};
	endfunction

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task step(input int n);
		repeat (n) begin
			@(posedge clk);
			#10;
		end
	endtask

	task close_out;
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		#2000000;
		err_count++;
		close_out;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		err_count = 0;
		n_compared = 0;
		seed = 32'h5f;
		rst_n = 1'b0;
		secTick = 1'b0;
		newSample = 1'b1;
		dataValid = 1'b1;
		virtualTemperatureCheckFail = 1'b0;
		fillCount = 8'h00;
		avgTimeSec = 8'h05;
		tempDiff = 8'h00;
		heat = '0;
		step(20);
		check(opByte, 8'h00);
		check(telByte, 8'h40);
		check(faultByte, 8'h00);
		rst_n = 1'b1;
		step(3);
		for (int k = 0; k < 70; k++) begin
			seed = xs(seed);
			fillCount = (k < 10) ? cf[k] : 8'(seed[15:0] % 201);
			tempDiff = (k < 10) ? ct[k] : seed[23:16];
			heat = seed[25:24];
			dataValid = seed[26];
			step(1);
			check(opByte, exp_op(fillCount, heat));
			check(telByte, exp_tel(fillCount, tempDiff, heat, dataValid));
			check(faultByte, 8'h00);
		end
		fillCount = 8'h00;
		newSample = 1'b0;
		secTick = 1'b1;
		step(9);
		check(faultByte, 8'h00);
		step(2);
		check(faultByte, 8'h01);
		step(50);
		check(faultByte, 8'h01);
		step(15);
		check(faultByte, 8'h03);
		newSample = 1'b1;
		step(2);
		check(faultByte, 8'h02);
		step(1);
		check(faultByte, 8'h00);
		virtualTemperatureCheckFail = 1'b1;
		step(50);
		check(faultByte, 8'h00);
		step(20);
		check(faultByte, 8'h02);
		virtualTemperatureCheckFail = 1'b0;
		secTick = 1'b0;
		step(1);
		check(faultByte, 8'h02);
		step(1);
		check(faultByte, 8'h00);
		for (int k = 0; k < 5; k++) begin
			avgTimeSec = la[k];
			fillCount = lf[k];
			step(1);
			check(faultByte, le[k]);
		end
		close_out;
	end
endmodule
